/* ptm_consts.svh */
/*
  Address map, reset values, field masks and timing figures of the test
  pattern and crossover timer block.
  Assumes it is included by bare name from the block's source files.
*/
`ifndef PTM_CONSTS_SVH
`define PTM_CONSTS_SVH

`define PTM_ADDR_W 8
`define PTM_CLK_PERIOD_NS 20

`define PTM_TEST_CFG_ADDR 8'h28
`define PTM_XOVER_ADDR 8'h2C
`define PTM_STATUS_ADDR 8'h30

`define PTM_TEST_CFG_RESET 16'h0480
`define PTM_XOVER_RESET 16'h141F
`define PTM_TEST_CFG_MASK 16'h0FFF
`define PTM_XOVER_MASK 16'h3FFF

`define PTM_CH_ALL_BIT 2
`define PTM_ALL_LANES 4'hF

`define PTM_FLD_UNIT_NS 1000
`define PTM_FAST_UNIT_US 4000
`define PTM_ROBUST_FULL_MS 500
`define PTM_ROBUST_FULL_STEPS 15

`define PTM_LFSR_SEED 16'hACE1
`define PTM_RESP_OKAY 2'h0
`define PTM_RESP_SLVERR 2'h2

`endif

/* ptm_pkg.sv */
/*
  Types of the test pattern and crossover timer block: register layouts,
  pattern codes, modes and the stimulus carrier.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ptm_pkg;

  typedef enum logic [3:0] {
    PTM_PAT_NLP = 4'b0000,
    PTM_PAT_PULSE1 = 4'b0001,
    PTM_PAT_PULSE0 = 4'b0010,
    PTM_PAT_REP1 = 4'b0011,
    PTM_PAT_REP0 = 4'b0100,
    PTM_PAT_PREAMBLE = 4'b0101,
    PTM_PAT_ONE_IDLE = 4'b0110,
    PTM_PAT_ZERO_IDLE = 4'b0111,
    PTM_PAT_SEQ1001 = 4'b1000,
    PTM_PAT_RANDOM = 4'b1001,
    PTM_PAT_IDLE_00 = 4'b1010,
    PTM_PAT_IDLE_01 = 4'b1011,
    PTM_PAT_IDLE_10 = 4'b1100
  } ptm_tbt_pat_t;

  typedef enum logic [1:0] {
    PTM_MODE_OFF = 2'b00,
    PTM_MODE_TBT = 2'b01,
    PTM_MODE_EXT100 = 2'b10
  } ptm_mode_t;

  typedef enum logic [1:0] {
    PTM_AMP_POS2 = 2'b00,
    PTM_AMP_NEG2 = 2'b01,
    PTM_AMP_POS1 = 2'b10,
    PTM_AMP_NEG1 = 2'b11
  } ptm_amp_t;

  typedef struct packed {
    logic [3:0] rsvd;
    ptm_amp_t test_pulse_amplitude_select;
    logic ext_pattern_zero_count_msb;
    logic ext_pattern_100m_enable;
    logic [2:0] stimulus_channel_select;
    logic tbt_enable;
    logic [3:0] pattern;
  } ptm_test_cfg_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [4:0] link_drop_window_count;
    logic [4:0] fast_crossover_timer;
    logic [3:0] robust_crossover_timer;
  } ptm_xover_cfg_t;

  typedef struct packed {
    logic drive;
    logic level;
    logic link_pulse;
    logic [1:0] idle_kind;
  } ptm_tx_sym_t;

  typedef struct packed {
    ptm_mode_t mode;
    logic [3:0] lanes;
    logic [3:0] drive;
    logic [3:0] level;
    logic link_pulse;
    logic [1:0] idle_kind;
  } ptm_stim_t;

endpackage : ptm_pkg

/* ptm_interval_timer.sv */
/*
  Interval timer: a prescaler of UNIT_CYCLES clocks and a unit counter that
  emits a one-cycle tick each time the programmed number of units elapses.
  Assumes interval is a static register field; zero means no ticks.
*/
`timescale 1ns/1ps
`default_nettype none

module ptm_interval_timer #(
  parameter int UNIT_CYCLES = 50,
  parameter int VAL_W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [VAL_W-1:0] interval,
  output logic tick_reg
);
  localparam int PW = $clog2(UNIT_CYCLES + 1);

  logic [PW-1:0] pre_reg;
  logic [VAL_W-1:0] units_reg;
  logic unit_end;
  logic last_unit;

  assign unit_end = (pre_reg == PW'(UNIT_CYCLES - 1));
  assign last_unit = ({1'b0, units_reg} + 1'b1) >= {1'b0, interval};

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || unit_end) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      units_reg <= '0;
    end else if (unit_end) begin
      units_reg <= last_unit ? '0 : units_reg + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= run && unit_end && last_unit && (interval != '0);
    end
  end

endmodule : ptm_interval_timer

`default_nettype wire

/* ptm_tbt_pattern.sv */
/*
  10BASE-T test pattern source: turns the 4-bit pattern code into one
  symbol per clock.
  Assumes restart pulses for one cycle whenever the configuration is written.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.svh"

module ptm_tbt_pattern
  import ptm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic restart,
  input wire logic [3:0] pattern,
  output ptm_tx_sym_t sym_reg
);
  logic fired_reg;
  logic [1:0] phase_reg;
  logic [15:0] lfsr_reg;
  ptm_tx_sym_t sym_next;
  logic seq_ok;

  // Single shot patterns fire once after enable or a fresh write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fired_reg <= 1'b0;
    end else begin
      fired_reg <= enable && !restart;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable || restart) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_reg <= `PTM_LFSR_SEED;
    end else if (enable) begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  always_comb begin
    sym_next = '0;
    if (enable && !restart) begin
      case (pattern)
        PTM_PAT_NLP: sym_next.link_pulse = !fired_reg;
        PTM_PAT_PULSE1: begin
          sym_next.drive = !fired_reg;
          sym_next.level = 1'b1;
        end
        PTM_PAT_PULSE0: sym_next.drive = !fired_reg;
        PTM_PAT_REP1: begin
          sym_next.drive = 1'b1;
          sym_next.level = 1'b1;
        end
        PTM_PAT_REP0: sym_next.drive = 1'b1;
        PTM_PAT_PREAMBLE: begin
          sym_next.drive = 1'b1;
          sym_next.level = !phase_reg[0];
        end
        PTM_PAT_ONE_IDLE: begin
          sym_next.drive = !fired_reg;
          sym_next.level = 1'b1;
        end
        PTM_PAT_ZERO_IDLE: sym_next.drive = !fired_reg;
        PTM_PAT_SEQ1001: begin
          sym_next.drive = 1'b1;
          sym_next.level = (phase_reg[1] == phase_reg[0]);
        end
        PTM_PAT_RANDOM: begin
          sym_next.drive = 1'b1;
          sym_next.level = lfsr_reg[0];
        end
        PTM_PAT_IDLE_00: sym_next.idle_kind = 2'b00;
        PTM_PAT_IDLE_01: sym_next.idle_kind = 2'b01;
        PTM_PAT_IDLE_10: sym_next.idle_kind = 2'b10;
        default: sym_next.idle_kind = 2'b10;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sym_reg <= '0;
    end else begin
      sym_reg <= sym_next;
    end
  end

  assign seq_ok = enable && !restart && (pattern == PTM_PAT_SEQ1001);

  chk_tbt_off_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> (sym_reg == '0))
    else $error("10BASE-T symbol active while test modes disabled");

  chk_repeat_ones: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && !restart && pattern == PTM_PAT_REP1)[*2] |=> sym_reg.drive && sym_reg.level)
    else $error("repetitive ones not driven");

  chk_preamble_alternates: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && !restart && pattern == PTM_PAT_PREAMBLE)[*2]
      |=> sym_reg.drive && (sym_reg.level != $past(sym_reg.level)))
    else $error("preamble does not alternate");

  chk_seq_1001_phase: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_ok |=> sym_reg.level == ($past(phase_reg) == 2'h0 || $past(phase_reg) == 2'h3))
    else $error("1001 sequence out of order");

  chk_high_codes_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && !restart && pattern > 4'hC) |=> !sym_reg.drive && sym_reg.idle_kind == 2'b10)
    else $error("undefined code produced stimulus");

endmodule : ptm_tbt_pattern

`default_nettype wire

/* ptm_test_stim_top.sv */
/*
  Test pattern stimulus and crossover timer configuration with an AXI4-Lite
  register slave, the 100M extended pattern generator, channel steering and
  the link drop window and crossover swap timers.
  Assumes one clock, synchronous active low reset and a single AXI4-Lite master.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.svh"

module ptm_test_stim_top
  import ptm_pkg::*;
#(
  parameter int FLD_UNIT_CYCLES = `PTM_FLD_UNIT_NS / `PTM_CLK_PERIOD_NS,
  parameter int FAST_UNIT_CYCLES = `PTM_FAST_UNIT_US * 1000 / `PTM_CLK_PERIOD_NS,
  parameter int ROBUST_UNIT_CYCLES =
    `PTM_ROBUST_FULL_MS * 1000000 / (`PTM_CLK_PERIOD_NS * `PTM_ROBUST_FULL_STEPS)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`PTM_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`PTM_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic crossover_hunt,
  input wire logic crossover_fast_mode,
  output ptm_stim_t stim,
  output ptm_amp_t test_pulse_amplitude_select,
  output logic mdix_swapped,
  output logic link_drop_window_tick
);
  ptm_test_cfg_t test_cfg_reg;
  ptm_xover_cfg_t xover_cfg_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [`PTM_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_commit;
  logic [`PTM_ADDR_W-1:0] wr_word;
  logic [`PTM_ADDR_W-1:0] rd_word;
  logic cfg_written_reg;
  logic [4:0] zero_count;
  logic ext_run;
  logic [4:0] ext_cnt_reg;
  logic ext_bit_reg;
  logic ext_drive_reg;
  ptm_tx_sym_t tbt_sym;
  ptm_mode_t mode;
  logic [3:0] chan_mask;
  ptm_stim_t stim_reg;
  ptm_amp_t amp_reg;
  logic fast_tick;
  logic robust_tick;
  logic fld_tick;
  logic mdix_swapped_reg;

  // Keep only the writable bits of a 16-bit register, merging byte lanes
  function automatic logic [15:0] ptm_merge(input logic [15:0] old_val,
                                            input logic [31:0] data,
                                            input logic [3:0] strb,
                                            input logic [15:0] mask);
    logic [15:0] merged;
    merged[7:0] = strb[0] ? data[7:0] : old_val[7:0];
    merged[15:8] = strb[1] ? data[15:8] : old_val[15:8];
    return merged & mask;
  endfunction : ptm_merge

  // AXI4-Lite write address and data, taken in either order
  assign wr_commit = aw_got_reg && w_got_reg && !bvalid;
  assign wr_word = {aw_addr_reg[`PTM_ADDR_W-1:2], 2'b00};
  assign rd_word = {araddr[`PTM_ADDR_W-1:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_got_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_got_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_commit) begin
      aw_got_reg <= 1'b0;
    end else if (!aw_got_reg && !bvalid && !awready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_got_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_got_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (wr_commit) begin
      w_got_reg <= 1'b0;
    end else if (!w_got_reg && !bvalid && !wready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `PTM_RESP_OKAY;
    end else if (wr_commit) begin
      bvalid <= 1'b1;
      if (wr_word == `PTM_TEST_CFG_ADDR || wr_word == `PTM_XOVER_ADDR) begin
        bresp <= `PTM_RESP_OKAY;
      end else begin
        bresp <= `PTM_RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Register storage; the status word is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_cfg_reg <= `PTM_TEST_CFG_RESET;
      xover_cfg_reg <= `PTM_XOVER_RESET;
    end else if (wr_commit && wr_word == `PTM_TEST_CFG_ADDR) begin
      test_cfg_reg <= ptm_merge(test_cfg_reg, w_data_reg, w_strb_reg, `PTM_TEST_CFG_MASK);
    end else if (wr_commit && wr_word == `PTM_XOVER_ADDR) begin
      xover_cfg_reg <= ptm_merge(xover_cfg_reg, w_data_reg, w_strb_reg, `PTM_XOVER_MASK);
    end
  end

  // A write to the test configuration restarts every running pattern except the random one, whose LFSR runs on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_written_reg <= 1'b0;
    end else begin
      cfg_written_reg <= wr_commit && wr_word == `PTM_TEST_CFG_ADDR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `PTM_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `PTM_RESP_OKAY;
      case (rd_word)
        `PTM_TEST_CFG_ADDR: rdata <= {16'h0000, test_cfg_reg};
        `PTM_XOVER_ADDR: rdata <= {16'h0000, xover_cfg_reg};
        `PTM_STATUS_ADDR: rdata <= {24'h000000, mdix_swapped_reg, ext_cnt_reg, mode};
        default: begin
          rdata <= '0;
          rresp <= `PTM_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid && !arready) begin
      arready <= 1'b1;
    end
  end

  // Extended 100M pattern: one 1 followed by zero_count zeros
  assign zero_count = {test_cfg_reg.ext_pattern_zero_count_msb, test_cfg_reg.pattern};
  assign ext_run = test_cfg_reg.ext_pattern_100m_enable && !test_cfg_reg.tbt_enable
                   && !cfg_written_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || !ext_run || zero_count == 5'h00) begin
      ext_cnt_reg <= 5'h00;
      ext_bit_reg <= 1'b0;
      ext_drive_reg <= 1'b0;
    end else if (ext_cnt_reg == 5'h00) begin
      ext_cnt_reg <= zero_count;
      ext_bit_reg <= 1'b1;
      ext_drive_reg <= 1'b1;
    end else begin
      ext_cnt_reg <= ext_cnt_reg - 5'h01;
      ext_bit_reg <= 1'b0;
      ext_drive_reg <= 1'b1;
    end
  end

  ptm_tbt_pattern u_tbt (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(test_cfg_reg.tbt_enable),
    .restart(cfg_written_reg),
    .pattern(test_cfg_reg.pattern),
    .sym_reg(tbt_sym)
  );

  // 10BASE-T test modes take precedence over the extended 100M pattern
  always_comb begin
    if (test_cfg_reg.tbt_enable) begin
      mode = PTM_MODE_TBT;
    end else if (test_cfg_reg.ext_pattern_100m_enable) begin
      mode = PTM_MODE_EXT100;
    end else begin
      mode = PTM_MODE_OFF;
    end
  end

  always_comb begin
    if (test_cfg_reg.stimulus_channel_select[`PTM_CH_ALL_BIT]) begin
      chan_mask = `PTM_ALL_LANES;
    end else begin
      chan_mask = 4'h1 << test_cfg_reg.stimulus_channel_select[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stim_reg <= '0;
    end else begin
      stim_reg.mode <= mode;
      case (mode)
        PTM_MODE_TBT: begin
          stim_reg.lanes <= chan_mask;
          stim_reg.drive <= tbt_sym.drive ? chan_mask : 4'h0;
          stim_reg.level <= tbt_sym.level ? chan_mask : 4'h0;
          stim_reg.link_pulse <= tbt_sym.link_pulse;
          stim_reg.idle_kind <= tbt_sym.idle_kind;
        end
        PTM_MODE_EXT100: begin
          stim_reg.lanes <= chan_mask;
          stim_reg.drive <= ext_drive_reg ? chan_mask : 4'h0;
          stim_reg.level <= ext_bit_reg ? chan_mask : 4'h0;
          stim_reg.link_pulse <= 1'b0;
          stim_reg.idle_kind <= 2'b00;
        end
        default: begin
          stim_reg.lanes <= 4'h0;
          stim_reg.drive <= 4'h0;
          stim_reg.level <= 4'h0;
          stim_reg.link_pulse <= 1'b0;
          stim_reg.idle_kind <= 2'b00;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      amp_reg <= PTM_AMP_NEG2;
    end else begin
      amp_reg <= test_cfg_reg.test_pulse_amplitude_select;
    end
  end

  // Link drop window and crossover swap timers
  ptm_interval_timer #(.UNIT_CYCLES(FLD_UNIT_CYCLES), .VAL_W(5)) u_fld_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(1'b1),
    .interval(xover_cfg_reg.link_drop_window_count),
    .tick_reg(fld_tick)
  );

  ptm_interval_timer #(.UNIT_CYCLES(FAST_UNIT_CYCLES), .VAL_W(5)) u_fast_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(crossover_hunt && crossover_fast_mode),
    .interval(xover_cfg_reg.fast_crossover_timer),
    .tick_reg(fast_tick)
  );

  ptm_interval_timer #(.UNIT_CYCLES(ROBUST_UNIT_CYCLES), .VAL_W(4)) u_robust_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(crossover_hunt && !crossover_fast_mode),
    .interval(xover_cfg_reg.robust_crossover_timer),
    .tick_reg(robust_tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdix_swapped_reg <= 1'b0;
    end else if (fast_tick || robust_tick) begin
      mdix_swapped_reg <= !mdix_swapped_reg;
    end
  end

  assign stim = stim_reg;
  assign test_pulse_amplitude_select = amp_reg;
  assign mdix_swapped = mdix_swapped_reg;
  assign link_drop_window_tick = fld_tick;

  chk_one_then_zeros: assert property (@(posedge aclk) disable iff (!aresetn)
    (ext_run && zero_count != 5'h00 && ext_cnt_reg == 5'h00)
      |=> ext_bit_reg && ext_cnt_reg == $past(zero_count) ##1 !ext_bit_reg)
    else $error("extended pattern does not send one then zeros");

  chk_zero_count_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (zero_count == 5'h00) |=> ext_cnt_reg == 5'h00 && !ext_drive_reg ##1 stim_reg.drive == 4'h0
      || stim_reg.mode != PTM_MODE_EXT100)
    else $error("zero count did not clear the shift register");

  chk_ext_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !test_cfg_reg.ext_pattern_100m_enable |=> !ext_drive_reg && stim_reg.mode != PTM_MODE_EXT100)
    else $error("extended pattern ran while disabled");

  chk_all_channels: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode != PTM_MODE_OFF && test_cfg_reg.stimulus_channel_select[`PTM_CH_ALL_BIT])
      |=> stim_reg.lanes == `PTM_ALL_LANES)
    else $error("all-channel select did not drive four channels");

  chk_single_channel: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode != PTM_MODE_OFF && !test_cfg_reg.stimulus_channel_select[`PTM_CH_ALL_BIT])
      |=> stim_reg.lanes == (4'h1 << $past(test_cfg_reg.stimulus_channel_select[1:0])))
    else $error("single channel steering wrong");

  chk_window_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> xover_cfg_reg.link_drop_window_count == 5'h0A
      && xover_cfg_reg.robust_crossover_timer == 4'hF)
    else $error("timer fields not at reset values");

  chk_fast_swap: assert property (@(posedge aclk) disable iff (!aresetn)
    fast_tick |=> mdix_swapped_reg != $past(mdix_swapped_reg))
    else $error("fast crossover tick did not swap");

  chk_robust_swap: assert property (@(posedge aclk) disable iff (!aresetn)
    (robust_tick && !fast_tick) |=> mdix_swapped_reg != $past(mdix_swapped_reg))
    else $error("robust crossover tick did not swap");

  chk_pulse_amplitude: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> ##1 amp_reg == PTM_AMP_NEG2 || $past(wr_commit))
    else $error("pulse amplitude not at reset setting");

endmodule : ptm_test_stim_top

`default_nettype wire

/* ptm_line_monitor.sv */
/* Line monitor standing for test equipment on channel A.
   Assumes the stimulus bus of the block and the block clock. */
`timescale 1ns/1ps
`default_nettype none
module ptm_line_monitor
  import ptm_pkg::*;
(
  input wire logic aclk,
  input wire logic clr,
  input wire ptm_stim_t stim,
  output logic [7:0] pulses,
  output logic [7:0] marks
);
  // Counts channel A cycles with a driven one, and with any drive or link pulse
  always_ff @(posedge aclk) begin
    if (clr) begin
      pulses <= 8'h00;
      marks <= 8'h00;
    end else begin
      pulses <= pulses + {7'h00, stim.lanes[0] & stim.drive[0] & stim.level[0]};
      marks <= marks + {7'h00, stim.lanes[0] & (stim.drive[0] | stim.link_pulse)};
    end
  end
endmodule : ptm_line_monitor
`default_nettype wire

/* phy_test_pattern_and_mdix_timers_bench.sv */
/* Bench of the test stimulus block: bus, patterns, steering, timers.
   Assumes shortened timer units and the channel A monitor. */
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.svh"
module phy_test_pattern_and_mdix_timers_bench
  import ptm_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic crossover_hunt = 0, crossover_fast_mode = 0, clr = 0;
  logic [7:0] awaddr = '0, araddr = '0, pulses, marks;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, mdix_swapped, link_drop_window_tick;
  logic [1:0] bresp, rresp;
  ptm_stim_t stim;
  ptm_amp_t test_pulse_amplitude_select;
  int n_mismatch = 0, compares = 0;
  int exp_ones [16] = '{0, 0, 0, 16, 0, 8, 0, 0, 8, 0, 0, 0, 0, 0, 0, 0};
  int exp_marks [16] = '{0, 0, 0, 16, 16, 16, 0, 0, 16, 16, 0, 0, 0, 0, 0, 0};
  int exp_shot [16] = '{0, 1, 0, 1, 0, 1, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0};
  ptm_test_stim_top #(.FLD_UNIT_CYCLES(4), .FAST_UNIT_CYCLES(8), .ROBUST_UNIT_CYCLES(6)) uut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .crossover_hunt, .crossover_fast_mode, .stim, .test_pulse_amplitude_select,
    .mdix_swapped, .link_drop_window_tick);
  ptm_line_monitor mon (.aclk, .clr, .stim, .pulses, .marks);
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s expected %0h seen %0h", n, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] e = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", {30'h0, e}, {30'h0, bresp});
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, re}, {30'h0, rresp});
    rready <= 1'b0;
  endtask : rd
  // Clears the running test before loading the new value
  task automatic cfg(input logic [15:0] v);
    wr(`PTM_TEST_CFG_ADDR, 16'h0000);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    wr(`PTM_TEST_CFG_ADDR, v);
    repeat (4) @(posedge aclk);
  endtask : cfg
  task automatic ones(input int n, input int e, input int em);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (n) @(posedge aclk);
    #1;
    chk("channel A ones", e, {24'h0, pulses});
    chk("channel A drives", em, {24'h0, marks});
  endtask : ones
  task automatic timers(input int n, input int et, input int es);
    logic p;
    int t;
    int s;
    t = 0;
    s = 0;
    repeat (4) @(posedge aclk);
    p = mdix_swapped;
    repeat (n) begin
      @(posedge aclk);
      t += link_drop_window_tick;
      s += (mdix_swapped !== p);
      p = mdix_swapped;
    end
    chk("window ticks", et, t);
    chk("swaps", es, s);
  endtask : timers
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PTM_TEST_CFG_ADDR, 32'h0480);
    rd(`PTM_XOVER_ADDR, 32'h141F);
    chk("amplitude", 32'h1, {30'h0, test_pulse_amplitude_select});
    rd(8'h40, 32'h0, 2'h2);
    wr(`PTM_STATUS_ADDR, 16'h0000, 2'h2);
    cfg(16'h0183);
    chk("mode", 32'h2, {30'h0, stim.mode});
    chk("lanes", 32'hF, {28'h0, stim.lanes});
    ones(16, 4, 16);
    cfg(16'h0381);
    ones(36, 2, 36);
    cfg(16'h0180);
    ones(16, 0, 0);
    rd(`PTM_STATUS_ADDR, 32'h2);
    cfg(16'h0C83);
    chk("mode", 32'h0, {30'h0, stim.mode});
    chk("amplitude", 32'h3, {30'h0, test_pulse_amplitude_select});
    for (int i = 0; i < 4; i++) begin
      cfg(16'h0103 | 16'(i << 5));
      chk("lanes", 32'h1 << i, {28'h0, stim.lanes});
    end
    for (int i = 0; i < 16; i++) begin
      cfg(16'h0010 | 16'(i));
      chk("shot drives", (i < 10) ? 32'h1 : 32'h0, {24'h0, marks});
      if (i != 9) chk("shot ones", exp_shot[i], {24'h0, pulses});
      chk("mode", 32'h1, {30'h0, stim.mode});
      if (i != 9) ones(16, exp_ones[i], exp_marks[i]);
      if (i > 9) chk("idle", (i > 12) ? 32'h2 : 32'(i - 10), {30'h0, stim.idle_kind});
    end
    crossover_hunt <= 1'b1;
    crossover_fast_mode <= 1'b1;
    wr(`PTM_XOVER_ADDR, 16'hC412);
    rd(`PTM_XOVER_ADDR, 32'h0412);
    timers(64, 8, 8);
    crossover_fast_mode <= 1'b0;
    timers(72, 9, 6);
    finish_test();
  end
  initial begin
    #400000;
    n_mismatch++;
    finish_test();
  end
endmodule : phy_test_pattern_and_mdix_timers_bench
`default_nettype wire
